// file: hw/spco_defs.vh
// Constants shared by the system port ordering block.
// Assumes it is included by bare name from design files.
`ifndef SPCO_DEFS_VH
`define SPCO_DEFS_VH
// Block offset inside a physical address and top of the probe index
`define SPCO_BLK_LSB  6
`define SPCO_IDX_MSB  19
// Miss file command codes
`define SPCO_CMD_W    3
`define SPCO_CMD_RD   3'h0
`define SPCO_CMD_RDM  3'h1
`define SPCO_CMD_FET  3'h2
`define SPCO_CMD_I2D  3'h3
`define SPCO_CMD_C2D  3'h4
`define SPCO_CMD_S2D  3'h5
`define SPCO_CMD_STC  3'h6
// Codes at or above this one are set-dirty upgrades
`define SPCO_CMD_UPG  3'h4
// Victim entries held back for probes
`define SPCO_VAF_RSV  1
`endif

// file: hw/spco_order.v
// Probe, victim file and miss file ordering at the system port.
// Assumes all inputs come from logic on i_mclk; requests are one-cycle pulses.
`timescale 1ns/1ns
`include "spco_defs.vh"

// Notes on behaviour
// - Probe responses leave in probe arrival order
// - Buffer releases accepted in any order
// - Each victim entry keeps victim and probe flags
// - Stall probe matching index of earlier probe entry
// - Keep one victim entry reserved for probes
// - Report victim hit once write was sent
// - Report miss hit on pending set-dirty upgrade
// - Invalidated lock fails store conditional, no refetch
// - Pending read-type commands never match probes
// - Victim-carrying reads handled like dirty victim write; here miss commands carry no victim, victims enter only by i_vic_req
// - Cache state updates follow probe arrival order
// - No miss entry aliasing a victim entry
// - Data transfers applied in interface arrival order
module spco_order #(
  parameter PA_W  = 44,
  parameter VAF_N = 8,
  parameter VAF_W = 3,
  parameter MAF_N = 8,
  parameter MAF_W = 3
) (
  input  wire                  i_mclk,
  input  wire                  i_sys_rst,
  input  wire                  i_probe_valid,
  input  wire [PA_W-1:0]       i_probe_addr,
  input  wire                  i_probe_inval,
  input  wire                  i_probe_dirty,
  output wire                  o_probe_ready,
  output wire                  o_resp_valid,
  output wire                  o_resp_vaf_hit,
  output wire                  o_resp_maf_hit,
  output wire                  o_resp_buf,
  output wire [VAF_W-1:0]      o_resp_idx,
  output wire                  o_upd_valid,
  output wire [PA_W-7:0]       o_upd_blk,
  output wire                  o_upd_inval,
  input  wire                  i_vic_req,
  input  wire [PA_W-1:0]       i_vic_addr,
  output wire                  o_vic_ack,
  output wire                  o_vic_nak,
  output wire [VAF_W-1:0]      o_vic_idx,
  input  wire                  i_vic_sent,
  input  wire [VAF_W-1:0]      i_vic_sent_idx,
  input  wire                  i_rel_valid,
  input  wire [VAF_W-1:0]      i_rel_idx,
  input  wire                  i_rel_probe,
  input  wire                  i_miss_req,
  input  wire [PA_W-1:0]       i_miss_addr,
  input  wire [`SPCO_CMD_W-1:0] i_miss_cmd,
  output wire                  o_miss_ack,
  output wire                  o_miss_nak,
  output wire [MAF_W-1:0]      o_miss_idx,
  input  wire                  i_dc_valid,
  input  wire [MAF_W-1:0]      i_dc_idx,
  output wire                  o_dc_done,
  output wire [MAF_W-1:0]      o_dc_idx,
  input  wire                  i_lock_set,
  input  wire [PA_W-1:0]       i_lock_addr,
  input  wire                  i_lock_clr,
  output wire                  o_lock_valid,
  output wire                  o_stc_fail
);
  localparam BA_W    = PA_W - `SPCO_BLK_LSB;
  localparam IDX_W   = `SPCO_IDX_MSB - `SPCO_BLK_LSB + 1;
  localparam ST_IDLE = 1'b0;
  localparam ST_EVAL = 1'b1;
  localparam [VAF_W:0] RSV_PLAIN = `SPCO_VAF_RSV;
  localparam [VAF_W:0] RSV_ALLOC = `SPCO_VAF_RSV + 1;

  // ***************************************
  // State
  // ***************************************
  reg             st_r;
  reg [BA_W-1:0]  pr_ba_r;
  reg             pr_inv_r;
  reg             pr_dty_r;
  reg [VAF_N-1:0] vv_r;
  reg [VAF_N-1:0] pv_r;
  reg [VAF_N-1:0] sent_r;
  reg [BA_W-1:0]  vba_r [0:VAF_N-1];
  reg [MAF_N-1:0] mv_r;
  reg [BA_W-1:0]  mba_r [0:MAF_N-1];
  reg [`SPCO_CMD_W-1:0] mcmd_r [0:MAF_N-1];
  reg             lock_v_r;
  reg [BA_W-1:0]  lock_ba_r;
  reg             rdy_r, rv_r, rvh_r, rmh_r, rbuf_r, uv_r, uinv_r;
  reg [VAF_W-1:0] ridx_r;
  reg [BA_W-1:0]  ublk_r;
  reg             vack_r, vnak_r, mack_r, mnak_r, dcd_r, stcf_r;
  reg [VAF_W-1:0] vidx_r;
  reg [MAF_W-1:0] midx_r, dcidx_r;

  wire [BA_W-1:0] vic_ba  = i_vic_addr[PA_W-1:`SPCO_BLK_LSB];
  wire [BA_W-1:0] miss_ba = i_miss_addr[PA_W-1:`SPCO_BLK_LSB];

  // ***************************************
  // Per-entry compares
  // ***************************************
  wire [VAF_N-1:0] vhit, vsent_hit, istall, vcf;
  wire [MAF_N-1:0] mhit;
  genvar g;
  generate
    for (g = 0; g < VAF_N; g = g + 1) begin : g_vaf
      assign vhit[g]      = (vv_r[g] | pv_r[g]) & (vba_r[g] == pr_ba_r);
      assign vsent_hit[g] = vv_r[g] & sent_r[g] & (vba_r[g] == pr_ba_r);
      assign istall[g]    = pv_r[g] & (vba_r[g][IDX_W-1:0] == pr_ba_r[IDX_W-1:0]);
      assign vcf[g]       = (vv_r[g] | pv_r[g]) & (vba_r[g] == miss_ba);
    end
    for (g = 0; g < MAF_N; g = g + 1) begin : g_maf
      // Read-type entries are not owned yet, so only upgrades match
      assign mhit[g] = mv_r[g] & (mcmd_r[g] >= `SPCO_CMD_UPG)
                       & (mba_r[g] == pr_ba_r);
    end
  endgenerate

  // ***************************************
  // Free search
  // ***************************************
  reg [VAF_W:0]   vcnt;
  reg [VAF_W-1:0] vlo, vhi, hidx;
  reg             vlo_f, mfree;
  reg [MAF_W-1:0] mlo;
  integer i;
  integer j;
  always @* begin
    vcnt  = {(VAF_W+1){1'b0}};
    vlo   = {VAF_W{1'b0}};
    vhi   = {VAF_W{1'b0}};
    hidx  = {VAF_W{1'b0}};
    vlo_f = 1'b0;
    mfree = 1'b0;
    mlo   = {MAF_W{1'b0}};
    for (i = VAF_N - 1; i >= 0; i = i - 1) begin
      if (!(vv_r[i] | pv_r[i])) begin
        vcnt = vcnt + {{VAF_W{1'b0}}, 1'b1};
        vlo  = i[VAF_W-1:0];
        vlo_f = 1'b1;
      end
      if (vhit[i]) begin
        hidx = i[VAF_W-1:0];
      end
    end
    for (i = 0; i < VAF_N; i = i + 1) begin
      if (!(vv_r[i] | pv_r[i])) begin
        vhi = i[VAF_W-1:0];
      end
    end
    for (i = MAF_N - 1; i >= 0; i = i - 1) begin
      if (!mv_r[i]) begin
        mlo   = i[MAF_W-1:0];
        mfree = 1'b1;
      end
    end
  end

  // A probe holding dirty data with no buffer hit needs a fresh entry
  wire            need_alloc = pr_dty_r & ~(|vhit);
  wire            go         = (st_r == ST_EVAL) & ~(|istall)
                               & ~(need_alloc & ~vlo_f);
  wire            go_alloc   = go & need_alloc;
  // Victims may only take an entry while one stays free for probes
  wire [VAF_W:0]  vneed      = go_alloc ? RSV_ALLOC : RSV_PLAIN;
  wire            vic_ok     = i_vic_req & (vcnt > vneed);
  wire            miss_ok    = i_miss_req & ~(|vcf) & mfree;
  wire            lock_kill  = go & pr_inv_r & lock_v_r & (lock_ba_r == pr_ba_r);

  // ***************************************
  // Registers
  // ***************************************
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      st_r     <= ST_IDLE;
      pr_ba_r  <= {BA_W{1'b0}};
      pr_inv_r <= 1'b0;
      pr_dty_r <= 1'b0;
      vv_r     <= {VAF_N{1'b0}};
      pv_r     <= {VAF_N{1'b0}};
      sent_r   <= {VAF_N{1'b0}};
      mv_r     <= {MAF_N{1'b0}};
      lock_v_r <= 1'b0;
      lock_ba_r <= {BA_W{1'b0}};
      rdy_r    <= 1'b0;
      rv_r     <= 1'b0;
      rvh_r    <= 1'b0;
      rmh_r    <= 1'b0;
      rbuf_r   <= 1'b0;
      ridx_r   <= {VAF_W{1'b0}};
      uv_r     <= 1'b0;
      ublk_r   <= {BA_W{1'b0}};
      uinv_r   <= 1'b0;
      vack_r   <= 1'b0;
      vnak_r   <= 1'b0;
      vidx_r   <= {VAF_W{1'b0}};
      mack_r   <= 1'b0;
      mnak_r   <= 1'b0;
      midx_r   <= {MAF_W{1'b0}};
      dcd_r    <= 1'b0;
      dcidx_r  <= {MAF_W{1'b0}};
      stcf_r   <= 1'b0;
    end else begin
      rv_r   <= 1'b0;
      uv_r   <= 1'b0;
      stcf_r <= 1'b0;
      // One probe in flight at a time keeps answers and updates in order
      case (st_r)
        ST_IDLE: begin
          rdy_r <= 1'b1;
          if (rdy_r && i_probe_valid) begin
            rdy_r    <= 1'b0;
            pr_ba_r  <= i_probe_addr[PA_W-1:`SPCO_BLK_LSB];
            pr_inv_r <= i_probe_inval;
            pr_dty_r <= i_probe_dirty;
            st_r     <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          if (go) begin
            rv_r   <= 1'b1;
            rvh_r  <= |vsent_hit;
            rmh_r  <= |mhit;
            rbuf_r <= (|(vhit & vv_r)) | need_alloc;
            ridx_r <= need_alloc ? vlo : hidx;
            uv_r   <= 1'b1;
            ublk_r <= pr_ba_r;
            uinv_r <= pr_inv_r;
            rdy_r  <= 1'b1;
            st_r   <= ST_IDLE;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
      // Releases first so that a same-cycle set wins
      if (i_rel_valid) begin
        if (i_rel_probe) begin
          pv_r[i_rel_idx] <= 1'b0;
        end else begin
          vv_r[i_rel_idx]   <= 1'b0;
          sent_r[i_rel_idx] <= 1'b0;
        end
      end
      if (i_vic_sent) begin
        sent_r[i_vic_sent_idx] <= 1'b1;
      end
      // Per-bit set so that a release of another entry in this cycle is kept
      if (go) begin
        for (j = 0; j < VAF_N; j = j + 1) begin
          if (vhit[j] && vv_r[j]) begin
            pv_r[j] <= 1'b1;
          end
        end
      end
      if (go_alloc) begin
        pv_r[vlo]   <= 1'b1;
        vba_r[vlo]  <= pr_ba_r;
        sent_r[vlo] <= 1'b0;
      end
      vack_r <= vic_ok;
      vnak_r <= i_vic_req & ~vic_ok;
      if (vic_ok) begin
        vv_r[vhi]   <= 1'b1;
        vba_r[vhi]  <= vic_ba;
        sent_r[vhi] <= 1'b0;
        vidx_r      <= vhi;
      end
      // Data transfers retire strictly one per cycle as they arrive
      dcd_r <= i_dc_valid;
      if (i_dc_valid) begin
        mv_r[i_dc_idx] <= 1'b0;
        dcidx_r        <= i_dc_idx;
      end
      mack_r <= miss_ok;
      mnak_r <= i_miss_req & ~miss_ok;
      if (miss_ok) begin
        mv_r[mlo]   <= 1'b1;
        mba_r[mlo]  <= miss_ba;
        mcmd_r[mlo] <= i_miss_cmd;
        midx_r      <= mlo;
      end
      // Invalidated lock fails the store conditional without a refetch
      if (i_lock_clr || lock_kill) begin
        lock_v_r <= 1'b0;
      end
      if (lock_kill) begin
        stcf_r <= 1'b1;
      end
      if (i_lock_set) begin
        lock_v_r  <= 1'b1;
        lock_ba_r <= i_lock_addr[PA_W-1:`SPCO_BLK_LSB];
      end
    end
  end

  assign o_probe_ready  = rdy_r;
  assign o_resp_valid   = rv_r;
  assign o_resp_vaf_hit = rvh_r;
  assign o_resp_maf_hit = rmh_r;
  assign o_resp_buf     = rbuf_r;
  assign o_resp_idx     = ridx_r;
  assign o_upd_valid    = uv_r;
  assign o_upd_blk      = ublk_r;
  assign o_upd_inval    = uinv_r;
  assign o_vic_ack      = vack_r;
  assign o_vic_nak      = vnak_r;
  assign o_vic_idx      = vidx_r;
  assign o_miss_ack     = mack_r;
  assign o_miss_nak     = mnak_r;
  assign o_miss_idx     = midx_r;
  assign o_dc_done      = dcd_r;
  assign o_dc_idx       = dcidx_r;
  assign o_lock_valid   = lock_v_r;
  assign o_stc_fail     = stcf_r;

endmodule

// file: verification/spco_order_monitor.sv
// Checker for the probe, victim, miss and retire handshakes of spco_order.
// Assumes it is bound into spco_order and sees only that module's ports.
`timescale 1ns/1ns
module spco_order_monitor #(
  parameter MAF_W = 3
) (
  input wire             i_mclk,
  input wire             i_sys_rst,
  input wire             i_probe_valid,
  input wire             o_probe_ready,
  input wire             o_resp_valid,
  input wire             o_resp_vaf_hit,
  input wire             o_resp_buf,
  input wire             o_upd_valid,
  input wire             o_upd_inval,
  input wire             i_vic_req,
  input wire             o_vic_ack,
  input wire             o_vic_nak,
  input wire             i_miss_req,
  input wire             o_miss_ack,
  input wire             o_miss_nak,
  input wire             i_dc_valid,
  input wire [MAF_W-1:0] i_dc_idx,
  input wire             o_dc_done,
  input wire [MAF_W-1:0] o_dc_idx,
  input wire             i_lock_set,
  input wire             o_lock_valid,
  input wire             o_stc_fail
);
  // ****************************************
  // Handshake properties
  // ****************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  ready_drop_a: assert property (i_probe_valid && o_probe_ready |=>
    !o_probe_ready && !o_resp_valid) else $error("probe taken twice or answered early");
  resp_pulse_a: assert property (o_resp_valid |=> !o_resp_valid)
    else $error("probe response longer than one cycle");
  resp_upd_a: assert property (o_resp_valid == o_upd_valid)
    else $error("state update apart from its response");
  vic_answer_a: assert property (i_vic_req |=> o_vic_ack != o_vic_nak)
    else $error("victim request without single answer");
  miss_answer_a: assert property (i_miss_req |=> o_miss_ack != o_miss_nak)
    else $error("miss request without single answer");
  dc_order_a: assert property (i_dc_valid |=> o_dc_done && o_dc_idx == $past(i_dc_idx))
    else $error("retire out of order");
  stc_inval_a: assert property (o_stc_fail |-> o_resp_valid && o_upd_inval)
    else $error("store conditional failed without invalidating probe");
  lock_kill_a: assert property (o_stc_fail && !$past(i_lock_set) |-> !o_lock_valid)
    else $error("lock survives invalidating probe");
  vic_hit_buf_a: assert property (o_resp_valid && o_resp_vaf_hit |-> o_resp_buf)
    else $error("victim hit without buffer");
endmodule

bind spco_order spco_order_monitor #(.MAF_W(MAF_W)) mon_u (.*);

// file: verification/spco_sys_model.sv
// System side model that presents one probe at a time and awaits its answer.
// Assumes the bench pulses i_go for one cycle between rising edges.
`timescale 1ns/1ns
module spco_sys_model #(
  parameter PA_W = 44
) (
  input  wire            i_mclk,
  input  wire            i_go,
  input  wire [PA_W-1:0] i_addr,
  input  wire            i_inval,
  input  wire            i_dirty,
  input  wire            i_ready,
  input  wire            i_resp,
  output reg             o_valid,
  output reg  [PA_W-1:0] o_addr,
  output reg             o_inval,
  output reg             o_dirty,
  output reg             o_busy
);
  // ****************************************
  // Sample on rise, drive on fall
  // ****************************************
  reg go_r, tk_r, rs_r;
  initial {o_valid, o_addr, o_inval, o_dirty, o_busy, go_r, tk_r, rs_r} = 0;
  always @(posedge i_mclk) begin
    go_r <= i_go;
    tk_r <= o_valid & i_ready;
    rs_r <= i_resp;
  end
  always @(negedge i_mclk) begin
    if (go_r) begin
      {o_valid, o_addr, o_inval, o_dirty, o_busy} <= {1'b1, i_addr, i_inval, i_dirty, 1'b1};
    end else if (tk_r) begin
      o_valid <= 1'b0;
      o_addr  <= ~o_addr; // Released lines must not keep the old block
    end
    if (rs_r) o_busy <= 1'b0;
  end
endmodule

// file: verification/spco_order_tb.sv
// Self-checking bench for spco_order with a probing system model.
// Assumes spco_defs.vh on the include path and the checker bound in.
`timescale 1ns/1ns
`include "spco_defs.vh"
module spco_order_tb;
  localparam PA_W = 44;
  logic i_mclk = 0, i_sys_rst = 1, go = 0, inv = 0, dty = 0, i_vic_req = 0, i_vic_sent = 0;
  logic i_rel_valid = 0, i_rel_probe = 0, i_miss_req = 0, i_dc_valid = 0, i_lock_set = 0;
  logic i_lock_clr = 0;
  logic [PA_W-1:0] i_vic_addr = 0, i_miss_addr = 0, i_lock_addr = 0, pa = 0, a = 0, m = 0;
  logic [2:0] i_vic_sent_idx = 0, i_rel_idx = 0, i_miss_cmd = 0, i_dc_idx = 0;
  wire i_probe_valid, i_probe_inval, i_probe_dirty, o_probe_ready, o_resp_valid, busy;
  wire o_resp_vaf_hit, o_resp_maf_hit, o_resp_buf, o_upd_valid, o_upd_inval, o_vic_ack;
  wire o_vic_nak, o_miss_ack, o_miss_nak, o_dc_done, o_lock_valid, o_stc_fail;
  wire [PA_W-1:0] i_probe_addr;
  wire [PA_W-7:0] o_upd_blk;
  wire [2:0] o_resp_idx, o_vic_idx, o_miss_idx, o_dc_idx;
  logic [7:0] qv[$], qm[$], qp[$], qd[$];
  logic [PA_W-6:0] qb[$];
  int bad_count = 0, n_compared = 0;
  spco_order dut_u (.*);
  spco_sys_model #(.PA_W(PA_W)) sys_u (.i_mclk(i_mclk), .i_go(go), .i_addr(pa),
    .i_inval(inv), .i_dirty(dty), .i_ready(o_probe_ready), .i_resp(o_resp_valid),
    .o_valid(i_probe_valid), .o_addr(i_probe_addr), .o_inval(i_probe_inval),
    .o_dirty(i_probe_dirty), .o_busy(busy));
  initial forever #2 i_mclk = ~i_mclk;
  // ****************************************
  // Tasks
  // ****************************************
  task chk(input logic [63:0] s, input logic [63:0] e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %0t seen %h want %h", $time, s, e);
    end
  endtask
  task end_sim;
    // Expected results that never showed up count against the run
    bad_count += qv.size() + qm.size() + qp.size() + qd.size() + qb.size();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task vic(input logic [PA_W-1:0] ad, input logic [7:0] e);
    @(negedge i_mclk);
    {i_vic_req, i_vic_addr} = {1'b1, ad};
    qv.push_back(e);
    @(negedge i_mclk);
    i_vic_req = 0;
  endtask
  task mis(input logic [PA_W-1:0] ad, input logic [2:0] c, input logic [7:0] e);
    @(negedge i_mclk);
    {i_miss_req, i_miss_addr, i_miss_cmd} = {1'b1, ad, c};
    qm.push_back(e);
    @(negedge i_mclk);
    i_miss_req = 0;
  endtask
  task rel(input logic [2:0] ix, input logic pr);
    @(negedge i_mclk);
    {i_rel_valid, i_rel_idx, i_rel_probe} = {1'b1, ix, pr};
    @(negedge i_mclk);
    i_rel_valid = 0;
  endtask
  task lock(input logic s);
    {i_lock_addr, i_lock_set, i_lock_clr} = {m, s, !s};
    @(negedge i_mclk);
    {i_lock_set, i_lock_clr} = 2'h0;
  endtask
  task pgo(input logic [PA_W-1:0] ad, input logic iv, input logic dt, input logic [7:0] e);
    @(negedge i_mclk);
    {go, pa, inv, dty} = {1'b1, ad, iv, dt};
    qp.push_back(e);
    qb.push_back({iv, ad[PA_W-1:6]});
    @(negedge i_mclk);
    go = 0;
  endtask
  task pwt;
    repeat (2) @(negedge i_mclk);
    for (int k = 0; k < 40 && busy; k++) @(negedge i_mclk);
    if (busy) bad_count++;
  endtask
  task prb(input logic [PA_W-1:0] ad, input logic iv, input logic dt, input logic [7:0] e);
    pgo(ad, iv, dt, e);
    pwt;
  endtask
  // ****************************************
  // Result watcher and sequence
  // ****************************************
  always @(posedge i_mclk) begin
    if (o_vic_ack | o_vic_nak) chk(8'({o_vic_ack, o_vic_ack ? o_vic_idx : 3'h0}), qv.pop_front());
    if (o_miss_ack | o_miss_nak) chk(8'({o_miss_ack, o_miss_ack ? o_miss_idx : 3'h0}), qm.pop_front());
    if (o_resp_valid) chk(8'({o_resp_buf ? o_resp_idx : 3'h0, o_resp_buf, o_resp_vaf_hit,
      o_resp_maf_hit, o_stc_fail}), qp.pop_front());
    if (o_upd_valid) chk(64'({o_upd_inval, o_upd_blk}), 64'(qb.pop_front()));
    if (o_dc_done) chk(8'(o_dc_idx), qd.pop_front());
  end
  initial begin
    #20000;
    bad_count++;
    end_sim;
  end
  initial begin
    void'($urandom(34187));
    repeat (10) @(negedge i_mclk);
    i_sys_rst = 0;
    repeat (2) @(negedge i_mclk);
    a = PA_W'({$urandom, $urandom});
    vic(a, 8'h0F);
    prb(a, 0, 0, 8'h78);
    rel(7, 1);
    @(negedge i_mclk);
    {i_vic_sent, i_vic_sent_idx} = 4'hF;
    @(negedge i_mclk);
    i_vic_sent = 0;
    prb(a, 0, 0, 8'h7C);
    rel(7, 1);
    mis(a, `SPCO_CMD_RD, 8'h00);
    vic(~a, 8'h0E);
    rel(6, 0);
    rel(7, 0);
    for (int k = 0; k < 8; k++) vic(PA_W'({$urandom, $urandom}), k < 7 ? 8'(15 - k) : 8'h00);
    for (int k = 1; k < 8; k++) rel(3'(k), 0);
    for (int c = 0; c < 7; c++) begin
      m = PA_W'({$urandom, $urandom});
      mis(m, 3'(c), 8'(8 + c));
      prb(m, 0, 0, c >= 4 ? 8'h02 : 8'h00);
    end
    for (int c = 0; c < 7; c++) begin
      @(negedge i_mclk);
      {i_dc_valid, i_dc_idx} = {1'b1, 3'(c)};
      qd.push_back(8'(c));
    end
    @(negedge i_mclk);
    i_dc_valid = 0;
    lock(1);
    prb(m, 1, 0, 8'h01);
    chk(8'(o_lock_valid), 8'h00);
    lock(1);
    prb(m, 0, 0, 8'h00);
    lock(0);
    chk(8'(o_lock_valid), 8'h00);
    prb(a, 1, 1, 8'h08);
    pgo(a ^ 44'h4000_0000, 0, 0, 8'h00); // Same index, other block: must wait
    repeat (8) @(negedge i_mclk);
    chk(8'(busy), 8'h01);
    chk(8'(o_probe_ready), 8'h00);
    rel(0, 1);
    pwt;
    end_sim;
  end
endmodule
